// ==== core/ifvu_top.sv ====
// Interrupt flag, enable and vector unit with APB register access
//
// Operation
// - Global enable gates all unmasked requests
// - Reset clears global enable
// - Return-from-interrupt sets global enable again
// - Taking interrupt clears enable, pushes, vectors 0004h
// - Pin events answered three to four cycles later
// - Flags set regardless of any enable
// - Pin edge polarity chosen by edge select
// - Selected pin edge sets pin flag
// - Pin enable bit masks pin interrupt
// - Pin wakes sleep only when enabled
// - Pin flag may set during Q4-Q1
// - Timer rollover FFh to 00h sets flag
// - Timer enable bit gates timer interrupt
// - Change on port pins 7:4 sets flag
// - Port change enable bit gates port interrupt
// - Exactly four request sources accepted
// - Enabled pin, port or EEPROM event wakes sleep whatever global enable
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ifvu_top (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    ext_irq_pin,
    input  wire logic [7:4]              port_b_pins,
    input  wire logic [7:0]              timer_zero_count,
    input  wire ifvu_pkg::ifvu_core_in_t core_in,
    output ifvu_pkg::ifvu_core_resp_t    core_resp,
    output logic                         irq_request,
    output logic                         wake_request
);
    // Pin synchroniser: bit 0 is the external pin, bits 4:1 the port pins
    logic [4:0]  pin_meta_q;
    logic [4:0]  pin_sync_q;
    logic [2:0]  sync_fill_q;
    logic        ext_prev_q;
    logic        ext_hold_q;
    logic [3:0]  port_latch_q;
    logic        port_valid_q;
    logic [7:0]  tmr_prev_q;

    logic [7:0]  intctl_q;
    logic [7:0]  intctl_d;
    logic [7:0]  option_q;
    logic        ee_flag_q;
    logic        ee_flag_d;

    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    ifvu_pkg::ifvu_resp_state_t state_q;
    ifvu_pkg::ifvu_resp_state_t state_d;
    logic [1:0]  wait_q;
    logic [1:0]  wait_d;
    ifvu_pkg::ifvu_core_resp_t  resp_q;
    logic        irq_q;
    logic        wake_q;

    logic [1:0]  q_phase;
    logic        icyc_start;

    ifvu_qphase u_qphase (
        .pclk       (pclk),
        .presetn    (presetn),
        .q_phase    (q_phase),
        .icyc_start (icyc_start)
    );

    // APB decode
    wire        setup      = psel & ~penable;
    wire        access     = psel & penable & pready_q;
    wire        hit_intctl = (paddr == ifvu_pkg::REG_INTCTL_OFS);
    wire        hit_option = (paddr == ifvu_pkg::REG_OPTION_OFS);
    wire        hit_aux    = (paddr == ifvu_pkg::REG_AUX_OFS);
    wire        hit_state  = (paddr == ifvu_pkg::REG_STATE_OFS);
    wire        hit_any    = hit_intctl | hit_option | hit_aux | hit_state;
    wire        wr_intctl  = access & pwrite & hit_intctl;
    wire        wr_option  = access & pwrite & hit_option;
    wire        wr_aux     = access & pwrite & hit_aux;

    // Event detection
    wire        ext_s      = pin_sync_q[0];
    // Edges are ignored until the pin pipeline holds real samples, else a high pin looks like an edge
    wire        edge_rise  = ext_s & ~ext_prev_q & sync_fill_q[2];
    wire        edge_fall  = ~ext_s & ext_prev_q & sync_fill_q[2];
    wire        ext_edge   = option_q[ifvu_pkg::BIT_EDGE_SEL] ? edge_rise : edge_fall;
    wire        ext_window = (q_phase == ifvu_pkg::Q4_PHASE) | (q_phase == ifvu_pkg::Q1_PHASE);
    wire        ext_set    = (ext_edge | ext_hold_q) & ext_window;
    // Sampled once per instruction cycle, so shorter glitches can be missed
    wire        port_set   = icyc_start & port_valid_q & (pin_sync_q[4:1] != port_latch_q);
    wire        tmr_set    = (tmr_prev_q == ifvu_pkg::TMR_TOP) & (timer_zero_count == ifvu_pkg::TMR_ZERO);
    wire        ee_set     = core_in.eeprom_done;

    // Masking of the four sources
    wire        global_irq_enable        = intctl_q[ifvu_pkg::BIT_GIE];
    wire        ext_act    = intctl_q[ifvu_pkg::BIT_EXT_FLAG] & intctl_q[ifvu_pkg::BIT_EXT_EN];
    wire        tmr_act    = intctl_q[ifvu_pkg::BIT_TMR_FLAG] & intctl_q[ifvu_pkg::BIT_TMR_EN];
    wire        port_act   = intctl_q[ifvu_pkg::BIT_PORT_FLAG] & intctl_q[ifvu_pkg::BIT_PORT_EN];
    wire        ee_act     = ee_flag_q & intctl_q[ifvu_pkg::BIT_EE_EN];
    wire        irq_req    = ext_act | tmr_act | port_act | ee_act;
    // Timer cannot run while asleep, so it is no wake source
    wire        wake_src   = ext_act | port_act | ee_act;
    wire        resp_start = (state_q == ifvu_pkg::RESP_IDLE) & icyc_start & global_irq_enable & irq_req
                             & ~core_in.sleeping;

    // Read mux
    wire [7:0]  state_rd   = {5'h00, core_in.sleeping, irq_req, (state_q != ifvu_pkg::RESP_IDLE)};
    wire [7:0]  rd_byte    = hit_intctl ? intctl_q :
                             hit_option ? option_q :
                             hit_aux    ? {7'h00, ee_flag_q} :
                             hit_state  ? state_rd : 8'h00;

    always_comb
    begin
        intctl_d = wr_intctl ? pwdata[7:0] : intctl_q;
        // Hardware set wins over a software write of zero
        if (ext_set)
            intctl_d[ifvu_pkg::BIT_EXT_FLAG] = 1'b1;
        if (tmr_set)
            intctl_d[ifvu_pkg::BIT_TMR_FLAG] = 1'b1;
        if (port_set)
            intctl_d[ifvu_pkg::BIT_PORT_FLAG] = 1'b1;
        if (resp_start)
            intctl_d[ifvu_pkg::BIT_GIE] = 1'b0;
        else if (core_in.return_from_irq_instr)
            intctl_d[ifvu_pkg::BIT_GIE] = 1'b1;
        ee_flag_d = (wr_aux ? pwdata[ifvu_pkg::BIT_EE_FLAG] : ee_flag_q) | ee_set;
    end

    // Response sequencer: lets the current instruction finish first
    always_comb
    begin
        state_d = state_q;
        wait_d  = wait_q;
        case (state_q)
            ifvu_pkg::RESP_IDLE:
            begin
                if (resp_start)
                begin
                    state_d = ifvu_pkg::RESP_WAIT;
                    wait_d  = ifvu_pkg::RESP_WAIT_ICYC;
                end
            end
            ifvu_pkg::RESP_WAIT:
            begin
                if (icyc_start)
                begin
                    wait_d = 2'(wait_q - 2'h1);
                    if (wait_q == 2'h1)
                        state_d = ifvu_pkg::RESP_FIRE;
                end
            end
            ifvu_pkg::RESP_FIRE:
                state_d = ifvu_pkg::RESP_IDLE;
            default:
                state_d = ifvu_pkg::RESP_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta_q   <= 5'h00;
            pin_sync_q   <= 5'h00;
            sync_fill_q  <= 3'h0;
            ext_prev_q   <= 1'b0;
            ext_hold_q   <= 1'b0;
            port_latch_q <= 4'h0;
            port_valid_q <= 1'b0;
            tmr_prev_q   <= 8'h00;
        end
        else
        begin
            pin_meta_q <= {port_b_pins, ext_irq_pin};
            pin_sync_q <= pin_meta_q;
            sync_fill_q <= {sync_fill_q[1:0], 1'b1};
            ext_prev_q <= ext_s;
            ext_hold_q <= (ext_edge | ext_hold_q) & ~ext_window;
            tmr_prev_q <= timer_zero_count;
            if (icyc_start)
            begin
                port_latch_q <= pin_sync_q[4:1];
                port_valid_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            intctl_q  <= ifvu_pkg::INTCTL_RST;
            option_q  <= ifvu_pkg::OPTION_RST;
            ee_flag_q <= ifvu_pkg::EE_FLAG_RST;
        end
        else
        begin
            intctl_q  <= intctl_d;
            ee_flag_q <= ee_flag_d;
            if (wr_option)
                option_q <= pwdata[7:0];
        end
    end

    // Setup-phase capture gives a one-cycle access phase with flopped outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit_any;
            if (setup)
                prdata_q <= {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ifvu_pkg::RESP_IDLE;
            wait_q  <= 2'h0;
            resp_q  <= '0;
            irq_q   <= 1'b0;
            wake_q  <= 1'b0;
        end
        else
        begin
            state_q         <= state_d;
            wait_q          <= wait_d;
            resp_q.push     <= (state_d == ifvu_pkg::RESP_FIRE);
            resp_q.vec_load <= (state_d == ifvu_pkg::RESP_FIRE);
            resp_q.vector   <= ifvu_pkg::IRQ_VECTOR;
            irq_q           <= irq_req & global_irq_enable;
            wake_q          <= core_in.sleeping & wake_src;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign core_resp    = resp_q;
    assign irq_request  = irq_q;
    assign wake_request = wake_q;

    AST_GIE_AFTER_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> !intctl_q[ifvu_pkg::BIT_GIE])
        else $error("global enable set after reset");

    AST_NO_TAKE_WHEN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (!global_irq_enable && state_q == ifvu_pkg::RESP_IDLE) |=> (state_q == ifvu_pkg::RESP_IDLE))
        else $error("response started with global enable clear");

    AST_RETURN_SETS_GIE: assert property (@(posedge pclk) disable iff (!presetn)
        (core_in.return_from_irq_instr && !resp_start) |=> global_irq_enable)
        else $error("return did not set global enable");

    AST_TAKE_CLEARS_GIE: assert property (@(posedge pclk) disable iff (!presetn)
        resp_start |=> !global_irq_enable ##0 (state_q == ifvu_pkg::RESP_WAIT))
        else $error("taking interrupt left global enable set");

    AST_VECTOR_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(resp_q.vec_load) |-> resp_q.push && resp_q.vector == ifvu_pkg::IRQ_VECTOR
        ##1 !resp_q.vec_load)
        else $error("vector response malformed");

    AST_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
        resp_start |-> ##[9:13] resp_q.vec_load)
        else $error("vector response latency out of range");

    AST_EXT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        ext_set |=> intctl_q[ifvu_pkg::BIT_EXT_FLAG])
        else $error("pin edge did not set its flag");

    AST_EXT_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(intctl_q[ifvu_pkg::BIT_EXT_FLAG]) && !$past(wr_intctl) |->
        ($past(q_phase) == ifvu_pkg::Q4_PHASE || $past(q_phase) == ifvu_pkg::Q1_PHASE))
        else $error("pin flag set outside Q4-Q1");

    AST_TMR_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        tmr_set |=> intctl_q[ifvu_pkg::BIT_TMR_FLAG])
        else $error("timer rollover did not set its flag");

    AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
        (core_in.sleeping && ext_act) |=> wake_request)
        else $error("enabled pin event did not wake");
endmodule
`default_nettype wire

// ==== inc/ifvu_pkg.sv ====
// Constants, register map and carrier types of the interrupt flag/enable/vector unit
package ifvu_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0]  REG_INTCTL_OFS   = 8'h00;
    localparam logic [7:0]  REG_OPTION_OFS   = 8'h04;
    localparam logic [7:0]  REG_AUX_OFS      = 8'h08;
    localparam logic [7:0]  REG_STATE_OFS    = 8'h0C;

    // interrupt_control field positions
    localparam int          BIT_GIE          = 7;
    localparam int          BIT_EE_EN        = 6;
    localparam int          BIT_TMR_EN       = 5;
    localparam int          BIT_EXT_EN       = 4;
    localparam int          BIT_PORT_EN      = 3;
    localparam int          BIT_TMR_FLAG     = 2;
    localparam int          BIT_EXT_FLAG     = 1;
    localparam int          BIT_PORT_FLAG    = 0;

    // Option register and auxiliary register field positions
    localparam int          BIT_EDGE_SEL     = 6;
    localparam int          BIT_EE_FLAG      = 0;

    // State register field positions
    localparam int          BIT_ST_BUSY      = 0;
    localparam int          BIT_ST_REQ       = 1;
    localparam int          BIT_ST_SLEEP     = 2;

    // Reset values
    localparam logic [7:0]  INTCTL_RST       = 8'h00;
    localparam logic [7:0]  OPTION_RST       = 8'hFF;
    localparam logic        EE_FLAG_RST      = 1'h0;

    // Vector and timer constants
    localparam logic [12:0] IRQ_VECTOR       = 13'h0004;
    localparam logic [7:0]  TMR_TOP          = 8'hFF;
    localparam logic [7:0]  TMR_ZERO         = 8'h00;

    // Timing: one instruction cycle is four Q phases
    localparam int          PCLK_PERIOD_NS   = 5;
    localparam int          INSTR_CYCLE_NS   = 20;
    localparam int          ICYC_PCLK        = INSTR_CYCLE_NS / PCLK_PERIOD_NS;
    localparam logic [1:0]  Q1_PHASE         = 2'h0;
    localparam logic [1:0]  Q4_PHASE         = 2'h3;
    localparam logic [1:0]  LAST_PHASE       = 2'(ICYC_PCLK - 1);
    // Two boundaries keep the pin-to-vector latency inside three to four instruction cycles
    localparam logic [1:0]  RESP_WAIT_ICYC   = 2'h2;

    // Requests from the core sequencer, all on pclk
    typedef struct packed {
        logic        return_from_irq_instr;
        logic        sleeping;
        logic        eeprom_done;
    } ifvu_core_in_t;

    // Vectored response towards the core
    typedef struct packed {
        logic        push;
        logic        vec_load;
        logic [12:0] vector;
    } ifvu_core_resp_t;

    typedef enum logic [1:0] {
        RESP_IDLE,
        RESP_WAIT,
        RESP_FIRE
    } ifvu_resp_state_t;

endpackage

// ==== core/ifvu_qphase.sv ====
// Quarter-phase divider: Q phase count and instruction cycle start pulse
`timescale 1ns/1ps
`default_nettype none
module ifvu_qphase (
    input  wire logic       pclk,
    input  wire logic       presetn,
    output logic [1:0]      q_phase,
    output logic            icyc_start
);
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic       start_q;
    wire        wrap = (phase_q == ifvu_pkg::LAST_PHASE);

    assign phase_d = wrap ? ifvu_pkg::Q1_PHASE : 2'(phase_q + 2'h1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_q <= 2'h0;
            start_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            start_q <= wrap;
        end
    end

    // Start pulse coincides with phase Q1
    assign q_phase    = phase_q;
    assign icyc_start = start_q;
endmodule
`default_nettype wire

// ==== sim/ifvu_core_model.sv ====
// Behavioural core sequencer facing the vectored response port
`timescale 1ns/1ps
`default_nettype none
module ifvu_core_model (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire ifvu_pkg::ifvu_core_resp_t core_resp,
    input  wire logic                      sleep_lvl,
    input  wire logic                      ee_req,
    input  wire logic                      ret_req,
    output ifvu_pkg::ifvu_core_in_t        core_in,
    output int                             pushes
);
    logic in_svc_q;
    // A return outside a service routine would re-enable early, so it is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_in  <= '0;
            in_svc_q <= 1'b0;
            pushes   <= 0;
        end
        else
        begin
            core_in.sleeping    <= sleep_lvl;
            core_in.eeprom_done <= ee_req;
            core_in.return_from_irq_instr      <= ret_req && in_svc_q;
            if (core_resp.push && core_resp.vec_load)
            begin
                pushes   <= pushes + 1;
                in_svc_q <= 1'b1;
            end
            else if (ret_req)
            begin
                in_svc_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/irq_flag_enable_vector_unit_bench.sv ====
// Self-checking bench for the interrupt flag, enable and vector unit
`timescale 1ns/1ps
`default_nettype none
module irq_flag_enable_vector_unit_bench;
    localparam logic [7:0] A_IC = ifvu_pkg::REG_INTCTL_OFS;
    localparam logic [7:0] A_OP = ifvu_pkg::REG_OPTION_OFS;
    localparam logic [7:0] A_AX = ifvu_pkg::REG_AUX_OFS;
    localparam logic [7:0] A_ST = ifvu_pkg::REG_STATE_OFS;
    localparam int         LAT_LO = 3 * ifvu_pkg::ICYC_PCLK;
    localparam int         LAT_HI = 4 * ifvu_pkg::ICYC_PCLK;
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                      ext_irq_pin, sleep_lvl, ee_req, ret_req, irq_request, wake_request;
    logic [7:0]                paddr, timer_zero_count;
    logic [31:0]               pwdata, prdata, rd;
    logic [7:4]                port_b_pins;
    ifvu_pkg::ifvu_core_in_t   core_in;
    ifvu_pkg::ifvu_core_resp_t core_resp;
    int                        pushes, mismatches, checked, n, p0, k, m_ictl, m_opt;
    int                        enb[3] = '{5, 4, 3};
    int                        flb[3] = '{2, 1, 0};
    ifvu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins), .timer_zero_count(timer_zero_count),
        .core_in(core_in), .core_resp(core_resp), .irq_request(irq_request), .wake_request(wake_request));
    ifvu_core_model core (.pclk(pclk), .presetn(presetn), .core_resp(core_resp), .sleep_lvl(sleep_lvl),
        .ee_req(ee_req), .ret_req(ret_req), .core_in(core_in), .pushes(pushes));
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic end_sim();
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            mismatches++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wait_push();
        for (n = 1; n <= 40; n++)
        begin
            @(posedge pclk);
            if (core_resp.push === 1'b1)
                break;
        end
        if (n > 40)
        begin
            mismatches++;
            end_sim();
        end
    endtask
    task automatic pin(input logic v, input int c);
        ext_irq_pin <= v;
        tick(c);
    endtask
    initial
    begin
        {psel, penable, pwrite, ext_irq_pin, sleep_lvl, ee_req, ret_req} = '0;
        {paddr, timer_zero_count, pwdata, port_b_pins} = '0;
        presetn = 1'b0;
        mismatches = 0;
        checked = 0;
        n = $urandom(54002);
        tick(16);
        presetn <= 1'b1;
        m_ictl = 0;
        m_opt = 'hFF;
        rchk(A_IC, m_ictl);
        rchk(A_OP, m_opt);
        rchk(8'h10, 0);
        chk(err, 1'b1);
        m_opt = ($urandom & 'hFF) | 'h40;
        apb(1'b1, A_OP, m_opt);
        rchk(A_OP, m_opt);
        // All four sources fire with every enable clear
        k = 4 + ($urandom % 4);
        port_b_pins[k] <= 1'b1;
        ext_irq_pin <= 1'b1;
        ee_req <= 1'b1;
        timer_zero_count <= 8'hFE;
        tick(1);
        ee_req <= 1'b0;
        timer_zero_count <= 8'hFF;
        tick(1);
        timer_zero_count <= 8'h00;
        tick(16);
        m_ictl = 'h07;
        rchk(A_IC, m_ictl);
        rchk(A_AX, 1);
        chk(irq_request, 1'b0);
        apb(1'b1, A_IC, 0);
        apb(1'b1, A_AX, 0);
        rchk(A_IC, 0);
        // Falling select: only the falling edge counts
        m_opt = m_opt & 'hBF;
        apb(1'b1, A_OP, m_opt);
        pin(1'b0, 12);
        rchk(A_IC, 'h02);
        apb(1'b1, A_IC, 0);
        pin(1'b1, 12);
        rchk(A_IC, 0);
        apb(1'b1, A_OP, m_opt | 'h40);
        pin(1'b0, 12);
        for (k = 0; k < 3; k++)
        begin
            apb(1'b1, A_IC, (1 << enb[k]) | (1 << flb[k]));
            tick(4);
            chk(irq_request, 1'b0);
            rchk(A_ST, 'h02);
            apb(1'b1, A_IC, 'h80 | (1 << flb[k]));
            tick(4);
            chk(irq_request, 1'b0);
            apb(1'b1, A_IC, 0);
        end
        apb(1'b1, A_AX, 1);
        apb(1'b1, A_IC, 'h40);
        rchk(A_ST, 'h02);
        apb(1'b1, A_AX, 0);
        // Vectored response and return
        apb(1'b1, A_IC, 'h90);
        p0 = pushes;
        ext_irq_pin <= 1'b1;
        wait_push();
        chk(n >= LAT_LO && n <= LAT_HI, 1'b1);
        chk(core_resp.vec_load, 1'b1);
        chk(core_resp.vector, ifvu_pkg::IRQ_VECTOR);
        tick(4);
        chk(pushes, p0 + 1);
        rchk(A_IC, 'h12);
        apb(1'b1, A_IC, 'h10);
        ret_req <= 1'b1;
        tick(1);
        ret_req <= 1'b0;
        tick(4);
        rchk(A_IC, 'h90);
        chk(pushes, p0 + 1);
        // Wake from sleep with and without the pin enable
        sleep_lvl <= 1'b1;
        apb(1'b1, A_IC, 0);
        pin(1'b0, 8);
        pin(1'b1, 12);
        chk(wake_request, 1'b0);
        apb(1'b1, A_IC, 'h12);
        tick(3);
        chk(wake_request, 1'b1);
        rchk(A_ST, 'h06);
        chk(irq_request, 1'b0);
        apb(1'b1, A_IC, 'h92);
        tick(8);
        chk(irq_request, 1'b1);
        chk(pushes, p0 + 1);
        sleep_lvl <= 1'b0;
        wait_push();
        chk(core_resp.vector, ifvu_pkg::IRQ_VECTOR);
        // Reset in mid-run with the global enable set
        apb(1'b1, A_IC, 'h80);
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        rchk(A_IC, 0);
        rchk(A_OP, 'hFF);
        end_sim();
    end
endmodule
`default_nettype wire
